//--- design/cmbro_defines.vh
`ifndef CMBRO_DEFINES_VH
`define CMBRO_DEFINES_VH

// Opcode encodings, 10-bit instruction words; bit clear gives only the upper 8 bits
`define CMBRO_OP_CARRY_RESET   10'h006
`define CMBRO_OP_BIT_CLEAR_HI  8'h13
`define CMBRO_OP_ROTATE_RIGHT  10'h01d
`define CMBRO_OP_POWER_OFF     10'h002
`define CMBRO_OP_POWER_OFF_EN  10'h2a3
`define CMBRO_OP_NOP           10'h000

// Widths
`define CMBRO_OP_W    10
`define CMBRO_DATA_W  4
`define CMBRO_ADDR_W  9

// Field positions inside the instruction word
`define CMBRO_BIT_SEL_LSB  0
`define CMBRO_BIT_SEL_MSB  1
`define CMBRO_OP_HI_LSB    2
`define CMBRO_OP_HI_MSB    9

// Reset values
`define CMBRO_ACC_RST     4'h0
`define CMBRO_CARRY_RST   1'h0
`define CMBRO_WE_RST      1'h0
`define CMBRO_ADDR_RST    9'h000
`define CMBRO_WDATA_RST   4'h0
`define CMBRO_BACKUP_RST  1'h0

`endif

//--- design/cmbro_bit_clear.v
`timescale 1ns/10ps
// Clears one selected bit of a memory nibble, others untouched
module cmbro_bit_clear (
  // Operand
  input  wire [3:0] nibble_in,
  input  wire [1:0] bit_sel,
  // Result
  output wire [3:0] nibble_out
);

  // Mask built from the two immediate bits
  assign nibble_out = nibble_in & ~(4'h1 << bit_sel); // [RULE_05]

endmodule // cmbro_bit_clear

//--- design/cmbro_core.v
// Summary of operation
// [RULE_01] Enabled power-off enters RAM back-up, one cycle
// [RULE_02] Power-off without preceding enable is no-op
// [RULE_03] Rotate accumulator right through carry, one cycle
// [RULE_04] Old carry to bit 3, bit 0 to carry
// [RULE_05] Clear immediate bit j of memory at pointer
// [RULE_06] Carry reset clears carry, nothing else changes
`timescale 1ns/10ps
`include "cmbro_defines.vh"
module cmbro_core (
  // Clock and reset
  input  wire                      clk,
  input  wire                      reset_n,
  // Instruction issue
  input  wire                      instr_valid,
  input  wire [`CMBRO_OP_W-1:0]    instr_word,
  // Data memory read data, write port and data pointer
  input  wire [`CMBRO_ADDR_W-1:0]  data_pointer,
  input  wire [`CMBRO_DATA_W-1:0]  mem_rdata,
  output reg                       mem_we,
  output reg  [`CMBRO_ADDR_W-1:0]  mem_addr,
  output reg  [`CMBRO_DATA_W-1:0]  mem_wdata,
  // Architectural state
  output reg  [`CMBRO_DATA_W-1:0]  acc,
  output reg                       carry_flag,
  // Power state
  output reg                       ram_backup
);

  // Execution model: one instruction per cycle arrives with instr_valid,
  // and each one retires at the edge that takes it, so nothing here
  // stalls or skips. Back-up only raises ram_backup; stopping the clock
  // and the sequencer is left to the power control outside this block.
  // Instructions presented while in back-up still execute here.

  // One-hot power states; back-up is only left through reset
  localparam [2:0] PWR_RUN    = 3'h1;
  localparam [2:0] PWR_ARMED  = 3'h2;
  localparam [2:0] PWR_BACKUP = 3'h4;

  // Decoded instruction strobes, each qualified by instr_valid
  wire                      is_power_off_instr;
  wire                      is_power_off_en;
  wire                      is_rotate_acc_right_instr;
  wire                      is_mem_bit_clear_instr;
  wire                      is_carry_reset_instr;

  // Bit clear operand path
  wire [1:0]                bit_sel;
  wire [`CMBRO_DATA_W-1:0]  cleared_nibble;

  // Rotate result as {carry, accumulator}
  wire [`CMBRO_DATA_W:0]    rotated;

  // Power state machine
  reg  [2:0]                pwr_state;
  reg  [2:0]                next_pwr_state;

  // Next values of the accumulator and carry
  reg  [`CMBRO_DATA_W-1:0]  next_acc;
  reg                       next_carry_flag;

  // Next values of the write-back port
  reg                       next_mem_we;
  reg  [`CMBRO_ADDR_W-1:0]  next_mem_addr;
  reg  [`CMBRO_DATA_W-1:0]  next_mem_wdata;

  // Exact match of a full opcode word; gated by the valid strobe so an
  // idle bus that happens to hold an opcode does nothing
  function op_match;
    input                   valid;
    input [`CMBRO_OP_W-1:0] word;
    input [`CMBRO_OP_W-1:0] code;
    begin
      op_match = valid && (word == code);
    end
  endfunction

  // Match of the upper opcode bits only; the low bits carry an operand
  // and must not take part in the compare
  function op_match_hi;
    input                                        valid;
    input [`CMBRO_OP_W-1:0]                      word;
    input [`CMBRO_OP_HI_MSB-`CMBRO_OP_HI_LSB:0]  code;
    begin
      op_match_hi = valid && (word[`CMBRO_OP_HI_MSB:`CMBRO_OP_HI_LSB] == code);
    end
  endfunction

  // Rotate right through carry; result is {new carry, new accumulator}
  // so both halves come from one expression and cannot drift apart
  function [`CMBRO_DATA_W:0] rotate_right;
    input [`CMBRO_DATA_W-1:0] value;
    input                     cin;
    begin
      rotate_right = {value[0], cin, value[`CMBRO_DATA_W-1:1]}; // [RULE_04]
    end
  endfunction

  // Instruction decode
  assign is_power_off_instr        = op_match(instr_valid, instr_word, `CMBRO_OP_POWER_OFF);
  assign is_power_off_en           = op_match(instr_valid, instr_word, `CMBRO_OP_POWER_OFF_EN);
  assign is_rotate_acc_right_instr = op_match(instr_valid, instr_word, `CMBRO_OP_ROTATE_RIGHT);
  assign is_carry_reset_instr      = op_match(instr_valid, instr_word, `CMBRO_OP_CARRY_RESET);
  assign is_mem_bit_clear_instr    = op_match_hi(instr_valid, instr_word, `CMBRO_OP_BIT_CLEAR_HI);

  // Bit number straight from the immediate field
  assign bit_sel = instr_word[`CMBRO_BIT_SEL_MSB:`CMBRO_BIT_SEL_LSB]; // [RULE_05]

  // Rotate is always computed; it only lands when decoded
  assign rotated = rotate_right(acc, carry_flag); // [RULE_03]

  // Masking kept apart so other bit operations can share it
  cmbro_bit_clear cmbro_bit_clear_i (
    .nibble_in  (mem_rdata),
    .bit_sel    (bit_sel),
    .nibble_out (cleared_nibble)
  );

  // Accumulator and carry next values. Rotate and carry reset are
  // distinct opcodes, so the priority between them never matters.
  always @* begin
    next_acc        = acc;
    next_carry_flag = carry_flag;
    if (is_rotate_acc_right_instr) begin
      next_acc        = rotated[`CMBRO_DATA_W-1:0]; // [RULE_03] [RULE_04]
      next_carry_flag = rotated[`CMBRO_DATA_W];     // [RULE_04]
    end else if (is_carry_reset_instr) begin
      next_carry_flag = 1'h0;                       // [RULE_06]
    end
  end

  // Accumulator and carry registers; one instruction per edge, and
  // the accumulator is left alone by everything but the rotate
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc        <= `CMBRO_ACC_RST;
      carry_flag <= `CMBRO_CARRY_RST;
    end else begin
      acc        <= next_acc;
      carry_flag <= next_carry_flag;
    end
  end

  // Write-back next values. Address and data hold between writes so a
  // memory that samples late still sees a stable word.
  always @* begin
    next_mem_we    = 1'h0;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    if (is_mem_bit_clear_instr) begin
      next_mem_we    = 1'h1;           // [RULE_05]
      next_mem_addr  = data_pointer;   // [RULE_05]
      next_mem_wdata = cleared_nibble; // [RULE_05]
    end
  end

  // Write strobe lasts one cycle per bit clear; back-to-back clears
  // give one strobe each
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_we <= `CMBRO_WE_RST;
    end else begin
      mem_we <= next_mem_we;
    end
  end

  // Write address and data; registered so the memory sees clean values
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr  <= `CMBRO_ADDR_RST;
      mem_wdata <= `CMBRO_WDATA_RST;
    end else begin
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // Power state transitions. Only a valid instruction moves the arming;
  // cycles without an instruction neither arm nor disarm, and any other
  // instruction between enable and power-off spends the enable.
  always @* begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      PWR_RUN: begin
        if (is_power_off_en)
          next_pwr_state = PWR_ARMED;
        else if (is_power_off_instr)
          next_pwr_state = PWR_RUN;     // [RULE_02]
      end
      PWR_ARMED: begin
        if (is_power_off_instr)
          next_pwr_state = PWR_BACKUP;  // [RULE_01]
        else if (instr_valid && !is_power_off_en)
          next_pwr_state = PWR_RUN;     // [RULE_02]
      end
      PWR_BACKUP: begin
        next_pwr_state = PWR_BACKUP;    // [RULE_01]
      end
      default: begin
        // Illegal code: recover to running, never into back-up
        next_pwr_state = PWR_RUN;
      end
    endcase
  end

  // Power state register; a stray glitch cannot arm without an
  // explicit enable because reset lands in the running state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_state <= PWR_RUN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // Back-up flag from its own flop; it tracks the state one-for-one
  // so the output never glitches through the state decode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_backup <= `CMBRO_BACKUP_RST;
    end else begin
      ram_backup <= (next_pwr_state == PWR_BACKUP); // [RULE_01]
    end
  end

endmodule // cmbro_core

//--- test/cmbro_sva.sv
`timescale 1ns/10ps
module cmbro_sva (
  input wire       clk, reset_n, instr_valid, mem_we, carry_flag, ram_backup,
  input wire [9:0] instr_word,
  input wire [8:0] data_pointer, mem_addr,
  input wire [3:0] mem_rdata, mem_wdata, acc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  reg armed;
  // Invalid cycles leave the arming untouched
  always @(posedge clk or negedge reset_n) if (!reset_n) armed <= 1'b0; else if (instr_valid) armed <= instr_word == 10'h2a3;
  sequence s_op(logic [9:0] op); instr_valid && instr_word == op; endsequence
  a_backup_entry: assert property (s_op(10'h002) ##0 armed |=> ram_backup) else $error("power off missed");
  a_backup_refused: assert property (s_op(10'h002) ##0 !armed && !ram_backup |=> !ram_backup)
    else $error("power off not refused");
  a_backup_sticky: assert property (ram_backup |=> ram_backup) else $error("back-up state left");
  a_rot_acc: assert property (s_op(10'h01d) |=> acc == {$past(carry_flag), $past(acc[3:1])}) else $error("rotate acc");
  a_rot_carry: assert property (s_op(10'h01d) |=> carry_flag == $past(acc[0])) else $error("rotate carry");
  a_bit_clear: assert property (instr_valid && instr_word[9:2] == 8'h13 |=>
    mem_we && mem_addr == $past(data_pointer)
    && mem_wdata == ($past(mem_rdata) & ~(4'h1 << $past(instr_word[1:0])))) else $error("bit clear");
  a_no_stray_write: assert property (!(instr_valid && instr_word[9:2] == 8'h13) |=> !mem_we)
    else $error("stray write");
  a_carry_rst: assert property (s_op(10'h006) |=> !carry_flag && $stable(acc) && !mem_we) else $error("carry reset");
endmodule // cmbro_sva
bind cmbro_core cmbro_sva cmbro_sva_i (.*);

//--- test/cmbro_core_tb.sv
`timescale 1ns/10ps
module cmbro_core_tb;
  reg clk = 0, reset_n = 0, instr_valid = 0, en = 0, b = 0, c = 0, we = 0;
  reg [9:0] instr_word = 0;
  reg [8:0] data_pointer = 0, wr_addr;
  reg [3:0] mem_rdata = 0, a = 0, wd;
  wire mem_we, carry_flag, ram_backup;
  wire [8:0] mem_addr;
  wire [3:0] mem_wdata, acc;
  integer seed = 32'h6e45, error_cnt = 0, checks = 0, cyc = 0, i;
  reg [9:0] ops [0:6];
  cmbro_core cmbro_core_i (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .data_pointer(data_pointer), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .acc(acc), .carry_flag(carry_flag), .ram_backup(ram_backup));
  always #4 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 1000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  task chk(input [15:0] s, input [15:0] e); begin
    checks = checks + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  end endtask
  // Expected nibble after clearing bit j, written bit-wise
  function [3:0] exp_clear(input [3:0] n, input [1:0] j); begin
    exp_clear = n;
    exp_clear[j] = 1'b0;
  end endfunction
  // Drive one cycle, model it at the edge, compare just after
  task step(input v, input [9:0] w); begin
    instr_valid = v; instr_word = w; data_pointer = $random(seed); mem_rdata = $random(seed);
    @(posedge clk);
    we = 0;
    wr_addr = data_pointer;
    wd = exp_clear(mem_rdata, w[1:0]);
    if (v) begin
      if (w == 10'h006) c = 0;
      if (w == 10'h01d) {a, c} = {c, a};
      if (w == 10'h002 && en) b = 1;
      if (w[9:2] == 8'h13) we = 1;
      en = w == 10'h2a3;
    end
    #1 chk({ram_backup, carry_flag, acc, mem_we}, {b, c, a, we});
    if (we) chk({mem_addr, mem_wdata}, {wr_addr, wd});
  end endtask
  // Mid-run reset: outputs clear and the arming is forgotten
  task do_reset; begin
    reset_n = 0;
    instr_valid = 0;
    a = 0;
    c = 0;
    b = 0;
    en = 0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1;
  end endtask
  task give_verdict; begin
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  initial begin
    ops[0] = 10'h006; ops[1] = 10'h04c; ops[2] = 10'h04d; ops[3] = 10'h04e;
    ops[4] = 10'h04f; ops[5] = 10'h01d; ops[6] = 10'h002;
    repeat (5) @(posedge clk);
    #1 reset_n = 1;
    for (i = 0; i < 400; i = i + 1) step($random(seed), ops[{$random(seed)} % 7]);
    // Enable spent on another instruction: power-off is refused
    step(1, 10'h2a3);
    step(1, 10'h01d);
    step(1, 10'h002);
    // An idle cycle between enable and power-off keeps the arming
    step(1, 10'h2a3);
    step(0, 10'h002);
    step(1, 10'h002);
    step(1, 10'h01d);
    // Reset in mid-run clears back-up; a repeated enable still arms
    do_reset;
    step(1, 10'h006);
    step(1, 10'h2a3);
    step(1, 10'h2a3);
    step(1, 10'h002);
    give_verdict;
  end
endmodule // cmbro_core_tb
